// File: core/smx_fifo.sv
`timescale 1ns/1ps
module smx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } smx_fifo_state_type;

  smx_fifo_state_type s_reg;
  smx_fifo_state_type s_next;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready_out  = (s_reg.cnt != CW'(DEPTH));
  assign out_valid_out = (s_reg.cnt != '0);
  assign out_data_out  = mem[s_reg.rd];
  assign level_out     = s_reg.cnt;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wr = AW'(s_reg.wr + 1'b1);
    end
    if (pop) begin
      s_next.rd = AW'(s_reg.rd + 1'b1);
    end
    if (push && !pop) begin
      s_next.cnt = CW'(s_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      s_next.cnt = CW'(s_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[s_reg.wr] <= in_data_in;
    end
  end
endmodule

// File: core/smx_pkg.sv
package smx_pkg;
  // ----------------------------------------
  // widths and link constants
  // ----------------------------------------
  localparam int DATA_W           = 8;
  localparam int FIFO_DEPTH       = 8;
  localparam int RX_FIFO_ENTRIES  = 2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // serial clock half period in core clocks, fixed in place of the prescaler
  localparam logic [7:0] HALF_PERIOD_DEFAULT = 8'h04;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ----------------------------------------
  // clock mode field encoding
  // ----------------------------------------
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10,
    ST_DONE  = 2'b11
  } smx_state_type;
endpackage

// File: core/smx_spi_core.sv
//
// Notes on behaviour
// R1: master: data write starts an eight-bit exchange with generated serial clock
// R2: master: transfer-done flag set when the byte has shifted out
// R3: select-pin-disable one: master ignores the select pin entirely
// R4: select pin as output: its level does not affect operation
// R5: select input low in master role clears master bit, becomes slave
// R6: forced switch to slave sets the transfer-done flag
// R7: software rewrites master bit to resume master; checks it before writes
// R8: master normal mode: write during transfer corrupts data, sets write collision
// R9: normal mode: received byte goes to first receive buffer, read via data
// R10: software reads first receive buffer before next transfer completes
// R11: normal mode: interrupt when transfer-done set and its enable is one
// R12: buffer-mode enable selects buffered path; wait-receive ignored in master
// R13: master buffered: writes accepted while buffer empty; first sent at once
// R14: buffered: received bytes enter two-entry receive fifo read via data
// R15: buffered: complete flag when shifter and buffer empty; interrupt if enabled
// R16: external master holds each clock phase over two core cycles
// R17: slave selected: drive data out when output enabled; others inputs
// R18: slave deselected: accept nothing, tri-state the data-out pin
// R19: slave: rising select resets state and bit count, drops partial byte
// R20: slave normal: idle while deselected, shift after select low, flag byte
// R21: slave normal: write during transfer discarded, sets write collision
// R22: buffered: empty flag drops on write, rises on move; receive flag next cycle
// R23: four clock polarity and phase modes, shift and latch on opposite edges
// R24: bit order zero sends msb first, one sends lsb first
//
`timescale 1ns/1ps
module smx_spi_core
  import smx_pkg::*;
(
  input  wire logic                       CLOCK_IN,
  input  wire logic                       RESETN_IN,
  input  wire logic                       ENABLE_IN,
  input  wire logic                       MASTER_SET_IN,
  output logic                            MASTER_OUT,
  input  wire logic [1:0]                 MODE_IN,
  input  wire logic                       BIT_ORDER_SELECT_IN,
  input  wire logic                       SELECT_PIN_DISABLE_IN,
  input  wire logic                       SELECT_PIN_IS_OUTPUT_IN,
  input  wire logic                       MISO_PORT_IS_OUTPUT_IN,
  input  wire logic                       BUFFER_MODE_ENABLE_IN,
  input  wire logic                       BUFFER_WAIT_RECEIVE_IN,
  input  wire logic                       TRANSFER_IRQ_ENABLE_IN,
  input  wire logic                       TRANSFER_COMPLETE_IRQ_ENABLE_IN,
  input  wire logic                       WR_VALID_IN,
  output logic                            WR_READY_OUT,
  input  wire logic [smx_pkg::DATA_W-1:0] WR_DATA_IN,
  output logic                            RD_VALID_OUT,
  input  wire logic                       RD_READY_IN,
  output logic      [smx_pkg::DATA_W-1:0] RD_DATA_OUT,
  input  wire logic                       FLAG_CLEAR_IN,
  output logic                            TRANSFER_DONE_FLAG_OUT,
  output logic                            WRITE_COLLISION_FLAG_OUT,
  output logic                            TX_BUFFER_EMPTY_FLAG_OUT,
  output logic                            RECEIVE_COMPLETE_FLAG_OUT,
  output logic                            TRANSFER_COMPLETE_FLAG_OUT,
  output logic                            IRQ_OUT,
  input  wire logic                       SCK_IN,
  output logic                            SCK_OUT,
  output logic                            SCK_OE_OUT,
  input  wire logic                       MOSI_IN,
  output logic                            MOSI_OUT,
  output logic                            MOSI_OE_OUT,
  input  wire logic                       MISO_IN,
  output logic                            MISO_OUT,
  output logic                            MISO_OE_OUT,
  input  wire logic                       SS_N_IN
);
  import smx_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    smx_state_type     st;
    logic              master;
    logic [7:0]        shifter;
    logic [2:0]        bit_cnt;
    logic [7:0]        div_cnt;
    logic              sck;
    logic              sampled;
    logic [7:0]        first_rx;
    logic              rx_valid;
    logic [7:0]        tx_buf;
    logic              tx_buf_full;
    logic              loaded;
    logic              done_flag;
    logic              wcol_flag;
    logic              rxc_flag;
    logic              rxc_pend;
    logic              txc_flag;
    logic              txc_pend;
    logic              sck_prev;
    logic              ss_prev;
    logic              out_bit;
  } smx_core_state_type;

  smx_core_state_type s_reg;
  smx_core_state_type s_next;

  logic       sck_s;
  logic       ss_s;
  logic       mosi_s;
  logic       miso_s;
  logic       cpol;
  logic       cpha;
  logic       ss_active;
  logic       slave_sel;
  logic       sck_lead;
  logic       sck_trail;
  logic       wr_take;
  logic       buffered;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic [7:0] fifo_out_data;
  logic [3:0] fifo_level;
  logic       ser_in;

  smx_sync #(.WIDTH(4)) u_sync (
    .clk_in    (CLOCK_IN),
    .resetn_in (RESETN_IN),
    .async_in  ({SCK_IN, SS_N_IN, MOSI_IN, MISO_IN}),
    .sync_out  ({sck_s, ss_s, mosi_s, miso_s})
  );

  // ----------------------------------------
  // receive fifo for buffered mode
  // ----------------------------------------
  smx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_in        (CLOCK_IN),
    .resetn_in     (RESETN_IN),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (RD_VALID_OUT),
    .out_ready_in  (RD_READY_IN && buffered),
    .out_data_out  (fifo_out_data),
    .level_out     (fifo_level)
  );

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = BYTE_ZERO;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction

  // outgoing bit is always shifter msb; lsb-first stores the byte reversed
  function automatic logic [7:0] order(input logic [7:0] v, input logic lsb_first);
    return lsb_first ? bit_rev(v) : v; // [R24]
  endfunction

  assign cpol      = (MODE_IN == MODE_2) || (MODE_IN == MODE_3); // [R23]
  assign cpha      = (MODE_IN == MODE_1) || (MODE_IN == MODE_3); // [R23]
  assign buffered  = BUFFER_MODE_ENABLE_IN; // [R12]
  // select only counts as a master abort when it is an enabled input
  assign ss_active = !SELECT_PIN_DISABLE_IN && !SELECT_PIN_IS_OUTPUT_IN; // [R3] [R4]
  assign slave_sel = ENABLE_IN && !s_reg.master && !ss_s;
  assign sck_lead  = (s_reg.sck_prev == cpol) && (sck_s != cpol);
  assign sck_trail = (s_reg.sck_prev != cpol) && (sck_s == cpol);
  assign ser_in    = s_reg.master ? miso_s : mosi_s;

  always_comb begin
    WR_READY_OUT = buffered ? !s_reg.tx_buf_full : 1'b1; // [R13]
  end
  assign wr_take = WR_VALID_IN && WR_READY_OUT && ENABLE_IN;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [7:0] rx_byte;
  logic       byte_end;
  // receive fifo limited to two entries; third byte is dropped
  assign fifo_in_data = rx_byte; // [R14]

  always_comb begin
    s_next        = s_reg;
    rx_byte       = order(s_reg.shifter, BIT_ORDER_SELECT_IN);
    byte_end      = 1'b0;
    fifo_in_valid = 1'b0;
    s_next.sck_prev = sck_s;
    s_next.ss_prev  = ss_s;
    s_next.rxc_flag = s_reg.rxc_flag | s_reg.rxc_pend; // [R22]
    s_next.rxc_pend = 1'b0;
    s_next.txc_flag = s_reg.txc_flag | s_reg.txc_pend;
    s_next.txc_pend = 1'b0;
    if (FLAG_CLEAR_IN) begin
      s_next.done_flag = 1'b0;
      s_next.wcol_flag = 1'b0;
      s_next.rxc_flag  = s_reg.rxc_pend;
      s_next.txc_flag  = s_reg.txc_pend;
    end
    if (MASTER_SET_IN) begin
      s_next.master = 1'b1; // [R7]
    end
    if (s_reg.master && ENABLE_IN && ss_active && !ss_s) begin
      s_next.master    = 1'b0; // [R5]
      s_next.done_flag = 1'b1; // [R6]
      s_next.st        = ST_IDLE;
      s_next.sck       = cpol;
    end else if (!s_reg.master && ss_s && !s_reg.ss_prev) begin
      s_next.st      = ST_IDLE; // [R19]
      s_next.bit_cnt = BIT_ZERO; // [R19]
    end else begin
      // data write path
      if (wr_take) begin
        if (buffered) begin
          if (s_reg.st == ST_IDLE && !s_reg.loaded && (s_reg.master || ss_s)) begin
            s_next.shifter = order(WR_DATA_IN, BIT_ORDER_SELECT_IN); // [R13]
            s_next.loaded  = 1'b1;
          end else begin
            s_next.tx_buf      = order(WR_DATA_IN, BIT_ORDER_SELECT_IN);
            s_next.tx_buf_full = 1'b1; // [R22]
          end
        end else if (s_reg.st != ST_IDLE) begin
          s_next.wcol_flag = 1'b1; // [R8] [R21]
          if (s_reg.master) begin
            s_next.shifter = order(WR_DATA_IN, BIT_ORDER_SELECT_IN); // [R8]
          end
        end else begin
          s_next.shifter = order(WR_DATA_IN, BIT_ORDER_SELECT_IN);
          s_next.loaded  = 1'b1;
        end
      end
      case (s_reg.st)
        ST_IDLE: begin
          s_next.sck     = cpol;
          s_next.div_cnt = HALF_PERIOD_DEFAULT;
          s_next.bit_cnt = BIT_ZERO;
          if (s_reg.master && s_reg.loaded && ENABLE_IN) begin
            s_next.st     = ST_LEAD; // [R1]
            s_next.loaded = 1'b0;
          end else if (slave_sel && (sck_lead || !cpha)) begin
            // phase one: this edge is already the first lead
            s_next.st      = cpha ? ST_TRAIL : ST_LEAD; // [R20]
            s_next.out_bit = s_reg.shifter[7];
            s_next.loaded  = 1'b0;
            if (!cpha) begin
              s_next.sampled = mosi_s;
            end
          end
        end
        ST_LEAD: begin
          if (s_reg.master) begin
            s_next.div_cnt = 8'(s_reg.div_cnt - COUNT_ONE);
            if (s_reg.div_cnt == COUNT_ONE) begin
              s_next.div_cnt = HALF_PERIOD_DEFAULT;
              s_next.sck     = !cpol;
              s_next.out_bit = s_reg.shifter[7]; // [R23]
              s_next.st      = ST_TRAIL;
              if (!cpha) begin
                s_next.sampled = ser_in;
              end
            end
          end else if (sck_lead && cpha) begin
            s_next.st      = ST_TRAIL;
            s_next.out_bit = s_reg.shifter[7]; // [R23]
          end else if (sck_trail && !cpha) begin
            s_next.shifter = {s_reg.shifter[6:0], s_reg.sampled}; // [R23]
            s_next.bit_cnt = 3'(s_reg.bit_cnt + 1'b1);
            byte_end       = (s_reg.bit_cnt == BIT_LAST);
          end else if (sck_lead) begin
            s_next.sampled = mosi_s;
          end
        end
        ST_TRAIL: begin
          if (s_reg.master) begin
            s_next.div_cnt = 8'(s_reg.div_cnt - COUNT_ONE);
            if (s_reg.div_cnt == COUNT_ONE) begin
              s_next.div_cnt = HALF_PERIOD_DEFAULT;
              s_next.sck     = cpol;
              s_next.bit_cnt = 3'(s_reg.bit_cnt + 1'b1);
              s_next.st      = ST_LEAD;
              s_next.shifter = {s_reg.shifter[6:0], cpha ? ser_in : s_reg.sampled};
              byte_end       = (s_reg.bit_cnt == BIT_LAST); // [R2]
            end
          end else if (sck_trail) begin
            s_next.shifter = {s_reg.shifter[6:0], mosi_s}; // [R23]
            s_next.bit_cnt = 3'(s_reg.bit_cnt + 1'b1);
            s_next.st      = ST_LEAD;
            byte_end       = (s_reg.bit_cnt == BIT_LAST);
          end
        end
        default: begin
          s_next.st = ST_IDLE;
        end
      endcase
      if (byte_end) begin
        rx_byte          = order(s_next.shifter, BIT_ORDER_SELECT_IN);
        s_next.st        = ST_IDLE;
        s_next.done_flag = 1'b1; // [R2] [R20]
        if (buffered) begin
          fifo_in_valid = fifo_level < 4'(RX_FIFO_ENTRIES); // [R14]
          if (s_reg.tx_buf_full) begin
            s_next.shifter     = s_reg.tx_buf; // [R22]
            s_next.tx_buf_full = 1'b0;
            s_next.loaded      = 1'b1;
            s_next.rxc_pend    = 1'b1; // [R22]
          end else begin
            s_next.rxc_pend = 1'b1;
            s_next.txc_pend = 1'b1; // [R15]
          end
        end else begin
          s_next.first_rx = rx_byte; // [R9]
          s_next.rx_valid = 1'b1;
        end
      end
    end
    if (!ENABLE_IN) begin
      s_next.st = ST_IDLE;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s_reg         <= '0;
      s_reg.st      <= ST_IDLE;
      s_reg.ss_prev <= 1'b1;
      s_reg.sck_prev <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign MASTER_OUT                 = s_reg.master;
  assign TRANSFER_DONE_FLAG_OUT     = s_reg.done_flag;
  assign WRITE_COLLISION_FLAG_OUT   = s_reg.wcol_flag;
  assign TX_BUFFER_EMPTY_FLAG_OUT   = !s_reg.tx_buf_full; // [R22]
  assign RECEIVE_COMPLETE_FLAG_OUT  = s_reg.rxc_flag;
  assign TRANSFER_COMPLETE_FLAG_OUT = s_reg.txc_flag;
  assign IRQ_OUT = (!buffered && s_reg.done_flag && TRANSFER_IRQ_ENABLE_IN) // [R11]
                || (buffered && s_reg.txc_flag && TRANSFER_COMPLETE_IRQ_ENABLE_IN); // [R15]
  assign RD_DATA_OUT = buffered ? fifo_out_data : s_reg.first_rx; // [R9] [R14]
  // pins: master drives clock and data out, slave only data out when selected
  assign SCK_OUT     = s_reg.sck;
  assign SCK_OE_OUT  = ENABLE_IN && s_reg.master;
  // phase one holds the bit from the lead edge so it never moves as it is sampled
  assign MOSI_OUT    = cpha ? s_reg.out_bit : s_reg.shifter[7]; // [R23]
  assign MOSI_OE_OUT = ENABLE_IN && s_reg.master;
  assign MISO_OUT    = cpha ? s_reg.out_bit : s_reg.shifter[7]; // [R23]
  assign MISO_OE_OUT = slave_sel && MISO_PORT_IS_OUTPUT_IN; // [R17] [R18]
endmodule

// File: core/smx_sync.sv
`timescale 1ns/1ps
module smx_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } smx_sync_state_type;

  smx_sync_state_type s_reg;
  smx_sync_state_type s_next;

  always_comb begin
    s_next.first  = async_in;
    s_next.second = s_reg.first;
  end

  // pins idle high so reset to ones avoids a false select edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.second;
endmodule

// File: verif/smx_spi_core_chk.sv
`timescale 1ns/1ps
module smx_spi_core_chk (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic ENABLE_IN,
  input wire logic MASTER_SET_IN,
  input wire logic MASTER_OUT,
  input wire logic SELECT_PIN_DISABLE_IN,
  input wire logic SELECT_PIN_IS_OUTPUT_IN,
  input wire logic MISO_PORT_IS_OUTPUT_IN,
  input wire logic BUFFER_MODE_ENABLE_IN,
  input wire logic TRANSFER_IRQ_ENABLE_IN,
  input wire logic TRANSFER_COMPLETE_IRQ_ENABLE_IN,
  input wire logic WR_READY_OUT,
  input wire logic TRANSFER_DONE_FLAG_OUT,
  input wire logic TX_BUFFER_EMPTY_FLAG_OUT,
  input wire logic TRANSFER_COMPLETE_FLAG_OUT,
  input wire logic IRQ_OUT,
  input wire logic SCK_OE_OUT,
  input wire logic MOSI_OE_OUT,
  input wire logic MISO_OE_OUT,
  input wire logic SS_N_IN
);
  // ----
  // select pin takeover, interrupts, full buffer and pin drive
  // ----
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence ss_pull;
    MASTER_OUT && ENABLE_IN && !SELECT_PIN_DISABLE_IN && !SELECT_PIN_IS_OUTPUT_IN && !SS_N_IN;
  endsequence
  sequence ss_held;
    (!SELECT_PIN_DISABLE_IN && !SELECT_PIN_IS_OUTPUT_IN && !SS_N_IN && !MASTER_SET_IN)[*4];
  endsequence
  a_disable_keeps_master: assert property (
    MASTER_OUT && ENABLE_IN && SELECT_PIN_DISABLE_IN |=> MASTER_OUT) else $error("master lost");
  a_ss_out_ignored: assert property (
    MASTER_OUT && ENABLE_IN && SELECT_PIN_IS_OUTPUT_IN |=> MASTER_OUT) else $error("master lost");
  a_ss_low_demote: assert property (
    ss_pull ##1 ss_held |-> ##[0:2] !MASTER_OUT) else $error("no demotion");
  a_demote_sets_done: assert property (
    $fell(MASTER_OUT) |-> ##[0:1] TRANSFER_DONE_FLAG_OUT) else $error("no done on demotion");
  a_irq_on_done: assert property (
    TRANSFER_DONE_FLAG_OUT && TRANSFER_IRQ_ENABLE_IN && !BUFFER_MODE_ENABLE_IN |-> IRQ_OUT)
    else $error("irq missing");
  a_irq_on_complete: assert property (
    TRANSFER_COMPLETE_FLAG_OUT && TRANSFER_COMPLETE_IRQ_ENABLE_IN && BUFFER_MODE_ENABLE_IN
    |-> IRQ_OUT) else $error("complete irq missing");
  a_full_refuses: assert property (
    BUFFER_MODE_ENABLE_IN && !TX_BUFFER_EMPTY_FLAG_OUT |-> !WR_READY_OUT)
    else $error("write taken while full");
  a_slave_pins_input: assert property (
    (!MASTER_OUT)[*2] |-> !SCK_OE_OUT && !MOSI_OE_OUT) else $error("slave drives input pin");
  a_select_miso_on: assert property (
    (!MASTER_OUT && ENABLE_IN && MISO_PORT_IS_OUTPUT_IN && !SS_N_IN)[*5] |-> MISO_OE_OUT)
    else $error("miso not driven");
  a_deselect_miso_off: assert property (
    (!MASTER_OUT && SS_N_IN)[*5] |-> !MISO_OE_OUT) else $error("miso driven");
  a_idle_deselected: assert property (
    (!MASTER_OUT && !BUFFER_MODE_ENABLE_IN && SS_N_IN)[*4] |=> !$rose(TRANSFER_DONE_FLAG_OUT))
    else $error("done while deselected");
endmodule

bind smx_spi_core smx_spi_core_chk smx_spi_core_chk_i (.*);

// File: verif/smx_spi_core_tb_top.sv
`timescale 1ns/1ps
module smx_spi_core_tb_top;
  import smx_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       en, mset, bord, spd, ssout, misoout, bfen, bfwr, irqen, tcie;
  logic       wv, rr, fclr, ss_n, tsck, tmosi, sel_n;
  logic [1:0] mode;
  logic [7:0] wd, m_tx, got, sd, sv, b2;
  wire  [7:0] rd_d, m_rx;
  wire        master, wrdy, rdv, done, wcol, txe, rxc, txc, irq, m_miso;
  wire        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire        sck_w = sck_oe ? sck_o : tsck;
  wire        mosi_w = mosi_oe ? mosi_o : tmosi;
  wire        miso_w = miso_oe ? miso_o : m_miso;
  int         err_total = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         n;
  always #10 clk = ~clk;
  smx_spi_core smx_spi_core_i (.CLOCK_IN(clk), .RESETN_IN(rstn), .ENABLE_IN(en),
    .MASTER_SET_IN(mset), .MASTER_OUT(master), .MODE_IN(mode), .BIT_ORDER_SELECT_IN(bord),
    .SELECT_PIN_DISABLE_IN(spd), .SELECT_PIN_IS_OUTPUT_IN(ssout),
    .MISO_PORT_IS_OUTPUT_IN(misoout), .BUFFER_MODE_ENABLE_IN(bfen),
    .BUFFER_WAIT_RECEIVE_IN(bfwr), .TRANSFER_IRQ_ENABLE_IN(irqen),
    .TRANSFER_COMPLETE_IRQ_ENABLE_IN(tcie), .WR_VALID_IN(wv), .WR_READY_OUT(wrdy),
    .WR_DATA_IN(wd), .RD_VALID_OUT(rdv), .RD_READY_IN(rr), .RD_DATA_OUT(rd_d),
    .FLAG_CLEAR_IN(fclr), .TRANSFER_DONE_FLAG_OUT(done), .WRITE_COLLISION_FLAG_OUT(wcol),
    .TX_BUFFER_EMPTY_FLAG_OUT(txe), .RECEIVE_COMPLETE_FLAG_OUT(rxc),
    .TRANSFER_COMPLETE_FLAG_OUT(txc), .IRQ_OUT(irq), .SCK_IN(sck_w), .SCK_OUT(sck_o),
    .SCK_OE_OUT(sck_oe), .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe),
    .MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe), .SS_N_IN(ss_n));
  smx_spi_slave_model smx_spi_slave_model_i (.clk_in(clk), .sck_in(sck_w), .mosi_in(mosi_w),
    .ss_n_in(sel_n), .mode_in(mode), .tx_in(m_tx), .miso_out(m_miso), .rx_out(m_rx));
  // ----
  // helpers
  // ----
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
  endfunction
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    int k;
    k = 0;
    wv = 1'b1;
    wd = d;
    #1;
    while (wrdy !== 1'b1 && k < 20) begin
      k++;
      tick;
    end
    tick;
    wv = 1'b0;
  endtask
  task automatic clr;
    rr = 1'b1;
    tick;
    rr = 1'b0;
    fclr = 1'b1;
    tick;
    fclr = 1'b0;
  endtask
  task automatic wait_done;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      n++;
      tick;
    end
  endtask
  task automatic mx(input logic [7:0] d, input logic [7:0] t);
    m_tx = t;
    sel_n = 1'b0;
    wr(d);
    wait_done;
    chk("done latency", 8'(n >= 60 && n < 120), 8'h01);
    chk("slave rx", m_rx, bord ? rev8(d) : d);
    chk("read data", rd_d, bord ? rev8(t) : t);
    chk("irq", {7'h00, irq}, {7'h00, irqen});
    clr;
    sel_n = 1'b1;
    tick;
  endtask
  // bench as external master, mode 0, half period of four core clocks
  task automatic sx(input logic [7:0] d, input int nb, input bit coll);
    ss_n = 1'b0;
    repeat (4) tick;
    for (int i = 0; i < nb; i++) begin
      tmosi = d[7-i];
      if (coll && i == 3) wr(8'h5A);
      repeat (4) tick;
      tsck = 1'b1;
      got = {got[6:0], miso_w};
      repeat (4) tick;
      tsck = 1'b0;
    end
    repeat (4) tick;
    ss_n = 1'b1;
    repeat (6) tick;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {en, mset, bord, spd, ssout, misoout, bfen, bfwr, irqen, tcie} = 10'h000;
    {wv, rr, fclr, tsck, tmosi} = 5'h00;
    {ss_n, sel_n} = 2'h3;
    mode = 2'h0;
    {wd, m_tx, got} = 24'h000000;
    void'($urandom(32'hD3889E4E));
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    tick;
    tick;
    chk("reset state", {txe, done, wcol, master}, 8'h08);
    {en, irqen, spd, mset} = 4'hF;
    tick;
    mset = 1'b0;
    for (int k = 0; k < 8; k++) begin
      mode = k[1:0];
      bord = k[2];
      bfwr = 1'($urandom);
      ss_n = 1'($urandom);
      tick;
      tick;
      mx((k == 0) ? 8'h80 : (k == 7) ? 8'hFF : 8'($urandom), 8'($urandom));
    end
    chk("master held", {7'h00, master}, 8'h01);
    {ss_n, mode, bord} = 4'h8;
    repeat (4) tick;
    spd = 1'b0;
    sel_n = 1'b0;
    wr(8'hA5);
    repeat (20) tick;
    wr(8'h3C);
    chk("collision", {7'h00, wcol}, 8'h01);
    wait_done;
    repeat (80) tick;
    clr;
    sel_n = 1'b1;
    ssout = 1'b1;
    ss_n = 1'b0;
    repeat (6) tick;
    chk("master kept", {7'h00, master}, 8'h01);
    ss_n = 1'b1;
    repeat (4) tick;
    ssout = 1'b0;
    tick;
    ss_n = 1'b0;
    repeat (6) tick;
    chk("master dropped", {7'h00, master}, 8'h00);
    chk("demote flag", {7'h00, done}, 8'h01);
    clr;
    ss_n = 1'b1;
    misoout = 1'b1;
    repeat (6) tick;
    chk("miso off", {7'h00, miso_oe}, 8'h00);
    sd = 8'($urandom);
    sv = 8'($urandom);
    wr(sd);
    sx(sv, 8, 1'b1);
    chk("miso byte", got, sd);
    chk("slave rx", rd_d, sv);
    chk("slave collision", {7'h00, wcol}, 8'h01);
    clr;
    sx(8'hF0, 3, 1'b0);
    chk("aborted done", {7'h00, done}, 8'h00);
    sv = 8'($urandom);
    sx(sv, 8, 1'b0);
    chk("after abort", rd_d, sv);
    chk("slave done", {7'h00, done}, 8'h01);
    clr;
    {spd, bfen, tcie, irqen, mset} = 5'h1D;
    tick;
    mset = 1'b0;
    sel_n = 1'b0;
    m_tx = 8'($urandom);
    b2 = 8'($urandom);
    wr(8'($urandom));
    tick;
    wr(b2);
    chk("buffer full", {7'h00, txe}, 8'h00);
    tick;
    wv = 1'b1;
    wd = 8'hEE;
    #1;
    chk("full refused", {7'h00, wrdy}, 8'h00);
    tick;
    wv = 1'b0;
    n = 0;
    while (txc !== 1'b1 && n < 400) begin
      n++;
      tick;
    end
    chk("complete", {txc, irq, txe}, 8'h07);
    chk("second byte", m_rx, b2);
    chk("rx flags", {6'h00, rxc, rdv}, 8'h03);
    chk("fifo head", rd_d, m_tx);
    sel_n = 1'b1;
    tally_and_finish;
  end
endmodule

// File: verif/smx_spi_slave_model.sv
`timescale 1ns/1ps
module smx_spi_slave_model (
  input  wire logic       clk_in,
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       ss_n_in,
  input  wire logic [1:0] mode_in,
  input  wire logic [7:0] tx_in,
  output logic            miso_out,
  output logic      [7:0] rx_out
);
  // ----
  // behavioural slave, msb first
  // ----
  int   ptr = 8;
  logic tog = 1'b0;
  logic lead;
  initial rx_out = 8'h00;
  // deselected line toggles so no stale bit passes for data
  always @(posedge clk_in) tog <= ~tog;
  always @(negedge ss_n_in) ptr = mode_in[0] ? -1 : 0;
  always @(sck_in) if (!ss_n_in) begin
    lead = (sck_in != mode_in[1]);
    if (lead != mode_in[0]) rx_out = {rx_out[6:0], mosi_in};
    else ptr = ptr + 1;
  end
  assign miso_out = (!ss_n_in && ptr >= 0 && ptr < 8) ? tx_in[7-ptr] : tog;
endmodule
